// ---- hw/spicsf_flags.sv ----
// Control register and sticky status flags of the serial port.
// Assumes a shift engine on clk supplying event pulses, and a CPU on the plain register port.
// Flags are set by one-cycle event pulses, mode fault by the select pin level, and cleared by software only.
//
// Contract
// - Set done flag when a transfer ends
// - Done flag requests interrupt when enabled
// - Flags stay set until software clears
// - Data write while busy sets collision
// - Select low, master, mode 01: fault
// - Fault and overrun also raise interrupt
// - Slave new byte over unread: overrun
// - Mode 00: three wire, pin unused
// - Mode 01 default: pin is input
// - Mode 1x: pin drives low bit
`timescale 1ns/100ps
`include "spicsf_map.svh"

module spicsf_flags
    import spicsf_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic [3:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    input  wire logic       data_wr,
    input  wire logic       xfer_busy,
    input  wire logic       xfer_end,
    input  wire logic       rx_byte_in,
    input  wire logic       rx_unread,
    input  wire logic       master_enable_bit,
    input  wire logic       tx_empty,
    input  wire logic       irq_enable,
    input  wire logic       slave_select_pin_in,
    output logic            slave_select_pin_out,
    output logic            slave_select_pin_oe,
    output logic            slave_select_active,
    output logic            port_enable,
    output logic            irq_req
);

    // ====================================================================
    // Declarations
    logic       done_ff,  nxt_done;
    logic       write_collision_flag_ff,  nxt_write_collision_flag;
    logic       mode_fault_flag_ff,  nxt_mode_fault_flag;
    logic       ovrn_ff,  nxt_ovrn;
    logic [1:0] ssm_ff,   nxt_ssm;
    logic       en_ff,    nxt_en;
    logic [7:0] rdata_ff, nxt_rdata;
    logic       irq_ff,   nxt_irq;
    logic       ssout_ff, nxt_ssout;
    logic       ssoe_ff,  nxt_ssoe;
    logic       ssact_ff, nxt_ssact;
    logic       ss_meta_ff;
    logic       ss_sync_ff;
    logic       ctrl_wr;
    logic       ctrl_rd;
    logic       set_done;
    logic       set_write_collision_flag;
    logic       set_mode_fault_flag;
    logic       set_ovrn;

    // Sticky flag update: set beats clear, write 1 keeps
    function automatic logic sticky(input logic cur, input logic set_ev, input logic wr, input logic wbit);
        sticky = set_ev | (cur & ~(wr & ~wbit));
    endfunction : sticky

    // Register address decode, shared by write and read paths
    function automatic logic ctrl_hit(input logic [3:0] addr);
        ctrl_hit = (addr == `SPICSF_CTRL_ADDR);
    endfunction : ctrl_hit

    // ====================================================================
    // Pin synchroniser
    // Only the second stage feeds logic
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ss_meta_ff <= 1'h1;
            ss_sync_ff <= 1'h1;
        end else begin
            ss_meta_ff <= slave_select_pin_in;
            ss_sync_ff <= ss_meta_ff;
        end
    end

    // ====================================================================
    // Register strobes and flag set events
    assign ctrl_wr  = reg_wr && ctrl_hit(reg_addr);
    assign ctrl_rd  = reg_rd && ctrl_hit(reg_addr);
    assign set_done = xfer_end;
    assign set_write_collision_flag = data_wr & xfer_busy;
    assign set_mode_fault_flag = ~ss_sync_ff & master_enable_bit & (ssm_ff == SPICSF_SSM_4W_MULTI);
    assign set_ovrn = rx_byte_in & rx_unread & ~master_enable_bit;

    // ====================================================================
    // Next-state of control and flags
    always_comb begin
        // no hardware clear
        // Set wins over a same-cycle clear
        nxt_done = sticky(done_ff, set_done, ctrl_wr, reg_wdata[`SPICSF_BIT_DONE]);
        nxt_write_collision_flag = sticky(write_collision_flag_ff, set_write_collision_flag, ctrl_wr, reg_wdata[`SPICSF_BIT_WRITE_COLLISION_FLAG]);
        nxt_mode_fault_flag = sticky(mode_fault_flag_ff, set_mode_fault_flag, ctrl_wr, reg_wdata[`SPICSF_BIT_MODE_FAULT_FLAG]);
        nxt_ovrn = sticky(ovrn_ff, set_ovrn, ctrl_wr, reg_wdata[`SPICSF_BIT_OVRN]);
        // Mode and enable follow a register write
        nxt_ssm  = ctrl_wr ? reg_wdata[`SPICSF_BIT_SSM_HI:`SPICSF_BIT_SSM_LO] : ssm_ff;
        nxt_en   = ctrl_wr ? reg_wdata[`SPICSF_BIT_ENABLE] : en_ff;
    end

    // Flag and control registers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            done_ff <= 1'h0;
            write_collision_flag_ff <= 1'h0;
            mode_fault_flag_ff <= 1'h0;
            ovrn_ff <= 1'h0;
            ssm_ff  <= `SPICSF_SSM_RESET;
            en_ff   <= `SPICSF_ENABLE_RESET;
        end else begin
            done_ff <= nxt_done;
            write_collision_flag_ff <= nxt_write_collision_flag;
            mode_fault_flag_ff <= nxt_mode_fault_flag;
            ovrn_ff <= nxt_ovrn;
            ssm_ff  <= nxt_ssm;
            en_ff   <= nxt_en;
        end
    end

    // ====================================================================
    // Read data, standing one cycle after the strobe
    always_comb begin
        nxt_rdata = 8'h00;
        if (ctrl_rd) begin
            nxt_rdata = {done_ff, write_collision_flag_ff, mode_fault_flag_ff, ovrn_ff, ssm_ff, tx_empty, en_ff};
        end
    end

    // Read data register
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdata_ff <= 8'h00;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    // ====================================================================
    // Interrupt request from any set flag
    always_comb begin
        nxt_irq = irq_enable & (nxt_done | nxt_mode_fault_flag | nxt_ovrn | nxt_write_collision_flag);
    end

    // Interrupt register
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irq_ff <= 1'h0;
        end else begin
            irq_ff <= nxt_irq;
        end
    end

    // ====================================================================
    // Select pin drive by mode
    // Next mode, so the pin follows a write in one cycle
    always_comb begin
        case (nxt_ssm)
            SPICSF_SSM_3WIRE: begin
                nxt_ssoe  = 1'h0;
                nxt_ssout = 1'h1;
                nxt_ssact = 1'h1;
            end
            SPICSF_SSM_4W_MULTI: begin
                nxt_ssoe  = 1'h0;
                nxt_ssout = 1'h1;
                nxt_ssact = ~ss_sync_ff;
            end
            SPICSF_SSM_4W_LOW, SPICSF_SSM_4W_HIGH: begin
                nxt_ssoe  = 1'h1;
                nxt_ssout = nxt_ssm[0];
                nxt_ssact = 1'h0;
            end
            default: begin
                nxt_ssoe  = 1'h0;
                nxt_ssout = 1'h1;
                nxt_ssact = 1'h0;
            end
        endcase
    end

    // ====================================================================
    // Select pin registers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ssout_ff <= 1'h1;
            ssoe_ff  <= 1'h0;
            ssact_ff <= 1'h0;
        end else begin
            ssout_ff <= nxt_ssout;
            ssoe_ff  <= nxt_ssoe;
            ssact_ff <= nxt_ssact;
        end
    end

    // ====================================================================
    // Outputs straight from registers
    assign reg_rdata            = rdata_ff;
    assign irq_req              = irq_ff;
    assign slave_select_pin_out = ssout_ff;
    assign slave_select_pin_oe  = ssoe_ff;
    assign slave_select_active  = ssact_ff;
    assign port_enable          = en_ff;

endmodule : spicsf_flags

// ---- hw/spicsf_map.svh ----
// Offsets, field positions, reset values of the serial port control register.
// Assumes inclusion by the flag block and its bench only.
`ifndef SPICSF_MAP_SVH
`define SPICSF_MAP_SVH

// ====================================================================
// Register address
`define SPICSF_CTRL_ADDR      4'h0

// ====================================================================
// Field positions inside the control register
`define SPICSF_BIT_DONE       7
`define SPICSF_BIT_WRITE_COLLISION_FLAG       6
`define SPICSF_BIT_MODE_FAULT_FLAG       5
`define SPICSF_BIT_OVRN       4
`define SPICSF_BIT_SSM_HI     3
`define SPICSF_BIT_SSM_LO     2
`define SPICSF_BIT_TXEMPTY    1
`define SPICSF_BIT_ENABLE     0

// ====================================================================
// Reset values
`define SPICSF_SSM_RESET      2'h1
`define SPICSF_ENABLE_RESET   1'h0

`endif

// ---- hw/spicsf_pkg.sv ----
// Types shared by the control and status flag block.
// Assumes the map header supplies all numbers.
package spicsf_pkg;

    // ====================================================================
    // Slave-select modes
    typedef enum logic [1:0] {
        SPICSF_SSM_3WIRE   = 2'h0,
        SPICSF_SSM_4W_MULTI = 2'h1,
        SPICSF_SSM_4W_LOW  = 2'h2,
        SPICSF_SSM_4W_HIGH = 2'h3
    } spicsf_ssm_t;

endpackage : spicsf_pkg

// ---- verification/spicsf_peer.sv ----
// Shift-engine peer: one frame of len cycles.
// Assumes go is a one-cycle pulse on clk.
`timescale 1ns/100ps
module spicsf_peer (
    input  wire logic       clk,
    input  wire logic       go,
    input  wire logic [3:0] len,
    output logic            busy,
    output logic            done
);
    logic [3:0] cnt_ff = 4'h0;
    // ====
    // Frame counter and end pulse
    always @(posedge clk) begin
        cnt_ff <= go ? len : cnt_ff - 4'(busy);
        done   <= cnt_ff == 4'h1;
    end
    assign busy = cnt_ff != 4'h0;
endmodule : spicsf_peer

// ---- verification/spicsf_flags_props.sv ----
// Checker of the flag block ports.
// Assumes binding onto spicsf_flags.
`timescale 1ns/100ps
module spicsf_flags_props (
    input wire logic       clk,
    input wire logic       sys_rst,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       data_wr,
    input wire logic       xfer_busy,
    input wire logic       xfer_end,
    input wire logic       rx_byte_in,
    input wire logic       rx_unread,
    input wire logic       master_enable_bit,
    input wire logic       irq_enable,
    input wire logic       slave_select_pin_out,
    input wire logic       slave_select_pin_oe,
    input wire logic       slave_select_active,
    input wire logic       irq_req
);
    wire w0 = reg_wr && reg_addr == 4'h0;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // ====
    // Flag and select checks
    chk_done_irq: assert property (irq_enable && xfer_end |=> irq_req)
        else $error("done gave no irq");
    chk_write_collision_flag_irq: assert property (irq_enable && data_wr && xfer_busy |=> irq_req)
        else $error("collision gave no irq");
    chk_ovrn_irq: assert property (irq_enable && rx_byte_in && rx_unread && !master_enable_bit |=> irq_req)
        else $error("overrun gave no irq");
    chk_flag_sticky: assert property (irq_req && irq_enable && !reg_wr |=> irq_req)
        else $error("flag dropped");
    chk_irq_gate: assert property (!irq_enable |=> !irq_req)
        else $error("irq while disabled");
    chk_ssm_drive: assert property (w0 && reg_wdata[3] |=> slave_select_pin_oe && slave_select_pin_out == $past(reg_wdata[2]))
        else $error("pin drive wrong");
    chk_ssm_input: assert property (w0 && reg_wdata[3:2] == 2'h1 |=> !slave_select_pin_oe)
        else $error("pin driven in mode 1");
    chk_ssm_3wire: assert property (w0 && reg_wdata[3:2] == 2'h0 |=> !slave_select_pin_oe && slave_select_active)
        else $error("three wire wrong");
    cover property (irq_enable && xfer_end);
    cover property (data_wr && xfer_busy);
    cover property (w0 && reg_wdata[3]);
endmodule : spicsf_flags_props
bind spicsf_flags spicsf_flags_props i_props (.*);

// ---- verification/spi_control_status_flags_tb.sv ----
// Bench of the flag block against a bench model.
// Assumes peer, design and checker compiled first.
`timescale 1ns/100ps
module spi_control_status_flags_tb;
    logic clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, data_wr = 0, mst = 0, te = 0, pin = 1, go = 0;
    logic [3:0] reg_addr = 0, len = 2, flg = 0;
    logic [7:0] reg_wdata = 0, rdata;
    logic [1:0] mode = 1;
    logic pe = 0, ien = 1, unread = 1, busy, done, oe, out, irq, act, pen;
    integer fails = 0, n_compared = 0, seed = 32'he4a9;
    always #20 clk = ~clk;
    spicsf_peer i_peer (.clk(clk), .go(go), .len(len), .busy(busy), .done(done));
    spicsf_flags i_dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(rdata), .data_wr(data_wr), .xfer_busy(busy), .xfer_end(done), .rx_byte_in(done),
        .rx_unread(unread), .master_enable_bit(mst), .tx_empty(te), .irq_enable(ien), .slave_select_pin_in(pin),
        .slave_select_pin_out(out), .slave_select_pin_oe(oe), .slave_select_active(act),
        .port_enable(pen), .irq_req(irq));
    // ====
    // Compare, verdict and bus tasks
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        n_compared++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task automatic final_report;
        if (fails == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : final_report
    task automatic rd(input logic [3:0] a);
        logic t;
        t = $random(seed);
        te <= t;
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk(rdata, a == 4'h0 ? {flg, mode, t, pe} : 8'h00);
        chk(irq, ien & |flg);
        @(posedge clk);
    endtask : rd
    task automatic wr(input logic [7:0] d);
        reg_addr <= 4'h0;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        {flg, mode, pe} = {flg & d[7:4], d[3:2], d[0]};
        #1 chk({oe, oe & out, act, pen}, {mode[1], &mode, (mode == 2'h0 || (mode == 2'h1 && !pin)), pe});
        chk(rdata, 8'h00);
        @(posedge clk);
    endtask : wr
    task automatic xfer(input logic c, input logic u);
        len <= 4'h2 + 4'({$random(seed)} % 8);
        go <= 1'b1;
        unread <= u;
        @(posedge clk);
        go <= 1'b0;
        data_wr <= c;
        @(posedge clk);
        data_wr <= 1'b0;
        for (int i = 0; busy; i++) begin
            if (i > 20) begin
                fails++;
                final_report;
            end
            @(posedge clk);
        end
        repeat (2) @(posedge clk);
        flg = flg | {1'b1, c, 1'b0, ~mst & u};
    endtask : xfer
    // ====
    // Scenarios
    initial begin
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        rd(4'h0);
        rd(4'h5);
        xfer(1'b1, 1'b1);
        repeat (2) rd(4'h0);
        wr(8'h55);
        rd(4'h0);
        for (int m = 0; m < 4; m++)
            wr({4'h0, 2'(m), 2'h1});
        wr(8'h05);
        xfer(1'b0, 1'b0);
        rd(4'h0);
        mst <= 1'b1;
        pin <= 1'b0;
        repeat (4) @(posedge clk);
        flg[1] = 1'b1;
        xfer(1'b0, 1'b1);
        rd(4'h0);
        ien <= 1'b0;
        rd(4'h0);
        final_report;
    end
endmodule : spi_control_status_flags_tb
